// ==== eds_pkg.sv ====
// constants for the extended data space pager
package eds_pkg;
  localparam int unsigned ADDR_W         = 16;
  localparam int unsigned PAGE_W         = 8;
  localparam int unsigned EA_W           = 24;
  localparam int unsigned OFFS_W         = 15;
  localparam logic [15:0] WINDOW_BIT     = 16'h8000;
  localparam logic [15:0] BASE_LO        = 16'h0800;
  localparam logic [15:0] BASE_HI        = 16'h7fff;
  localparam logic [7:0]  PAGE_ZERO      = 8'h00;
  localparam logic [7:0]  RD_PAGE_RESET  = 8'h01;
  localparam logic [7:0]  WR_PAGE_RESET  = 8'h01;
  localparam logic [7:0]  PSV_PAGE_BASE  = 8'h80;
  localparam logic [1:0]  TGT_BASE       = 2'h0;
  localparam logic [1:0]  TGT_EXT        = 2'h1;
  localparam logic [1:0]  TGT_PROG       = 2'h2;
  localparam logic [1:0]  TGT_NONE       = 2'h3;
endpackage : eds_pkg

// ==== eds_xlate.sv ====
// combinational address translation for one access
`timescale 1ns/1ps
module eds_xlate (
  input  wire logic [15:0] i_addr,
  input  wire logic        i_write,
  input  wire logic [7:0]  i_rd_page,
  input  wire logic [7:0]  i_wr_page,
  output logic      [23:0] o_ea,
  output logic      [1:0]  o_target,
  output logic             o_trap,
  output logic             o_ro_viol
);
  wire       in_window = (i_addr & eds_pkg::WINDOW_BIT) != 16'h0000;
  // program view is read-only and uses only the read page
  wire       prog_sel  = (i_rd_page >= eds_pkg::PSV_PAGE_BASE);
  wire [7:0] page      = (i_write && !prog_sel) ? i_wr_page : i_rd_page;
  wire       page_zero = in_window && (page == eds_pkg::PAGE_ZERO);
  wire       ro_viol   = in_window && i_write && prog_sel;

  // page joined with window offset forms the wide address
  assign o_ea = in_window ? {page, 1'b0, i_addr[14:0]}
                          : {8'h00, i_addr};
  assign o_target  = !in_window ? eds_pkg::TGT_BASE :
                     (page_zero || ro_viol) ? eds_pkg::TGT_NONE :
                     prog_sel ? eds_pkg::TGT_PROG : eds_pkg::TGT_EXT;
  assign o_trap    = page_zero;
  assign o_ro_viol = ro_viol;
endmodule : eds_xlate

// ==== eds_pager.sv ====
// paged extended data space address extension
`timescale 1ns/1ps
module eds_pager (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_req,
  input  wire logic        i_write,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_rd_page_we,
  input  wire logic        i_wr_page_we,
  input  wire logic [7:0]  i_page_wdata,
  output logic      [7:0]  o_rd_page,
  output logic      [7:0]  o_wr_page,
  output logic             o_valid,
  output logic      [23:0] o_ea,
  output logic             o_write,
  output logic             o_to_base,
  output logic             o_to_ext,
  output logic             o_to_prog,
  output logic             o_addr_trap
);
  logic [7:0]  rd_page;
  logic [7:0]  wr_page;
  logic [23:0] x_ea;
  logic [1:0]  x_target;
  logic        x_trap;
  logic        x_ro;

  eds_xlate u_xlate (
    .i_addr    (i_addr),
    .i_write   (i_write),
    .i_rd_page (rd_page),
    .i_wr_page (wr_page),
    .o_ea      (x_ea),
    .o_target  (x_target),
    .o_trap    (x_trap),
    .o_ro_viol (x_ro)
  );

  wire next_trap  = i_req && (x_trap || x_ro);
  wire next_base  = i_req && (x_target == eds_pkg::TGT_BASE);
  wire next_ext   = i_req && (x_target == eds_pkg::TGT_EXT);
  wire next_prog  = i_req && (x_target == eds_pkg::TGT_PROG) && !i_write;

  // page select registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_page <= eds_pkg::RD_PAGE_RESET;
      wr_page <= eds_pkg::WR_PAGE_RESET;
    end else begin
      if (i_rd_page_we) rd_page <= i_page_wdata;
      if (i_wr_page_we) wr_page <= i_page_wdata;
    end
  end

  // registered access outputs
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_valid     <= 1'b0;
      o_ea        <= 24'h000000;
      o_write     <= 1'b0;
      o_to_base   <= 1'b0;
      o_to_ext    <= 1'b0;
      o_to_prog   <= 1'b0;
      o_addr_trap <= 1'b0;
      o_rd_page   <= eds_pkg::RD_PAGE_RESET;
      o_wr_page   <= eds_pkg::WR_PAGE_RESET;
    end else begin
      o_valid     <= i_req;
      o_ea        <= x_ea;
      o_write     <= i_req && i_write;
      o_to_base   <= next_base;
      o_to_ext    <= next_ext;
      o_to_prog   <= next_prog;
      o_addr_trap <= next_trap;
      o_rd_page   <= i_rd_page_we ? i_page_wdata : rd_page;
      o_wr_page   <= i_wr_page_we ? i_page_wdata : wr_page;
    end
  end

  a_trap_page_zero: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req && i_addr[15] && !i_write && rd_page == 8'h00) |=> o_addr_trap)
    else $error("page zero read not trapped");
  a_base_direct: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req && !i_addr[15]) |=> (o_to_base && o_ea == {8'h00, $past(i_addr)} && !o_addr_trap))
    else $error("base access altered");
  a_read_page_used: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req && i_addr[15] && !i_write) |=> o_ea[23:16] == $past(rd_page))
    else $error("read used wrong page");
  a_write_page_used: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req && i_addr[15] && i_write && rd_page < 8'h80) |=> o_ea[23:16] == $past(wr_page))
    else $error("write used wrong page");
  a_prog_rd_only: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req && i_addr[15] && i_write && rd_page >= 8'h80) |=> (o_addr_trap && !o_to_prog))
    else $error("program view written");
  a_prog_rd_page: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req && i_addr[15] && !i_write && rd_page >= 8'h80) |=> (o_to_prog && o_ea[23:16] == $past(rd_page)))
    else $error("program view page wrong");
  a_window_offset: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req && i_addr[15]) |=> (o_ea[14:0] == $past(i_addr[14:0]) && !o_ea[15]))
    else $error("window offset wrong");
  a_ext_route: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req && i_addr[15] && !i_write && rd_page != 8'h00 && rd_page < 8'h80) |=> o_to_ext)
    else $error("paged data not routed");

  // routing and page register checks
  a_valid_follows: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_req
    |=> (o_valid && o_write == $past(i_write)))
    else $error("request not answered");

  a_idle_quiet: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_req
    |=> !(o_valid || o_write || o_to_base || o_to_ext || o_to_prog || o_addr_trap))
    else $error("output without request");

  a_target_onehot: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_valid
    |-> $onehot({o_to_base, o_to_ext, o_to_prog, o_addr_trap}))
    else $error("access not routed to one place");

  a_trap_cause: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_addr_trap
    |-> ($past(i_req) && $past(i_addr[15])))
    else $error("trap outside window");

  a_ext_cause: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_to_ext
    |-> ($past(i_req) && $past(i_addr[15])))
    else $error("paged route outside window");

  a_prog_cause: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_to_prog
    |-> ($past(i_req) && !$past(i_write) && $past(rd_page) >= 8'h80))
    else $error("program view without read page");

  a_base_cause: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_to_base
    |-> ($past(i_req) && !$past(i_addr[15])))
    else $error("base route from window");

  a_base_ea_high: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_to_base
    |-> (o_ea[23:15] == 9'h000))
    else $error("base address paged");

  a_prog_is_read: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_to_prog
    |-> (!o_write && o_ea[23]))
    else $error("program view access not a read");

  a_page_zero_write: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req && i_addr[15] && i_write && rd_page < 8'h80 && wr_page == 8'h00)
    |=> (o_addr_trap && !o_to_ext))
    else $error("page zero write not trapped");

  a_write_ext_route: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req && i_addr[15] && i_write && rd_page < 8'h80 && wr_page != 8'h00)
    |=> (o_to_ext && !o_addr_trap))
    else $error("paged write not routed");

  a_prog_no_ext: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req && i_addr[15] && !i_write && rd_page >= 8'h80)
    |=> (!o_to_ext && !o_addr_trap))
    else $error("program view read misrouted");

  a_prog_wr_ignored: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req && i_addr[15] && i_write && rd_page >= 8'h80)
    |=> (o_ea[23:16] == $past(rd_page)))
    else $error("write page used in program view");

  a_window_page_live: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (o_valid && !o_to_base && !o_addr_trap)
    |-> (o_ea[23:16] != 8'h00))
    else $error("page zero passed through window");

  a_rd_page_load: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_rd_page_we
    |=> (o_rd_page == $past(i_page_wdata)))
    else $error("read page not loaded");

  a_wr_page_load: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_wr_page_we
    |=> (o_wr_page == $past(i_page_wdata)))
    else $error("write page not loaded");

  a_rd_page_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_rd_page_we
    |=> $stable(o_rd_page))
    else $error("read page changed unloaded");

  a_wr_page_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_wr_page_we
    |=> $stable(o_wr_page))
    else $error("write page changed unloaded");

  a_base_page_free: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req && !i_addr[15])
    |=> (o_valid && !o_to_ext && !o_to_prog))
    else $error("base access sent to paged space");

  a_trap_read_zero: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req && i_addr[15] && !i_write && rd_page == 8'h00)
    |=> (o_ea[23:16] == 8'h00 && !o_to_ext))
    else $error("page zero read routed");

  a_ext_write_page: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (o_to_ext && o_write)
    |-> (o_ea[23:16] == $past(wr_page)))
    else $error("paged write page wrong");

  a_ext_read_page: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (o_to_ext && !o_write)
    |-> (o_ea[23:16] == $past(rd_page)))
    else $error("paged read page wrong");
endmodule : eds_pager

// ==== eds_mem_model.sv ====
// memory side model latching each routed access
`timescale 1ns/1ps
module eds_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_valid,
  input  wire logic [2:0]  i_tgt,
  input  wire logic [23:0] i_ea,
  output logic      [26:0] o_seen
);
  always_ff @(posedge i_clk) begin
    if (i_valid) begin
      o_seen <= {i_tgt, i_ea};
    end
  end
endmodule : eds_mem_model

// ==== tb_top.sv ====
// self-checking bench for the extended data space pager
`timescale 1ns/1ps
module tb_top;
  logic        i_clk = 0, i_arst_n = 0, i_req = 0, i_write = 0, i_rd_page_we = 0, i_wr_page_we = 0;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0]  i_page_wdata = 8'h00, o_rd_page, o_wr_page;
  logic        o_valid, o_write, o_to_base, o_to_ext, o_to_prog, o_addr_trap;
  logic [23:0] o_ea;
  logic [26:0] seen, e;
  int          miscompares = 0, checked = 0, cyc = 0;
  // rows: write, address, read page, write page
  logic [32:0] rows [9] = '{{1'b0, 16'h8010, 8'h05, 8'h02}, {1'b1, 16'h8abc, 8'h05, 8'h02},
    {1'b0, 16'h1234, 8'h05, 8'h02}, {1'b1, 16'h0800, 8'h00, 8'h00}, {1'b0, 16'hffff, 8'h00, 8'h04},
    {1'b1, 16'h8000, 8'h05, 8'h00}, {1'b0, 16'hc000, 8'h80, 8'h03}, {1'b0, 16'h8002, 8'hff, 8'h00},
    {1'b1, 16'h8002, 8'h80, 8'h03}};
  eds_pager dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_req(i_req), .i_write(i_write), .i_addr(i_addr),
    .i_rd_page_we(i_rd_page_we), .i_wr_page_we(i_wr_page_we), .i_page_wdata(i_page_wdata),
    .o_rd_page(o_rd_page), .o_wr_page(o_wr_page), .o_valid(o_valid), .o_ea(o_ea), .o_write(o_write),
    .o_to_base(o_to_base), .o_to_ext(o_to_ext), .o_to_prog(o_to_prog), .o_addr_trap(o_addr_trap));
  eds_mem_model mem (.i_clk(i_clk), .i_valid(o_valid), .i_tgt({o_to_prog, o_to_ext, o_to_base}),
    .i_ea(o_ea), .o_seen(seen));
  always #4 i_clk = ~i_clk;
  task automatic report_and_stop;
    if (miscompares == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [26:0] got, input logic [26:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // {trap, prog, ext, base, ea} worked out from an input row
  function automatic logic [27:0] expect_of(input logic [32:0] r);
    logic [7:0] pg;
    logic       trap;
    pg = (r[32] && !r[15]) ? r[7:0] : r[15:8];
    trap = r[31] && (pg == 8'h00 || (r[32] && r[15]));
    return {trap, r[31] && !trap && r[15], r[31] && !trap && !r[15], !r[31],
      r[31] ? {pg, 1'b0, r[30:16]} : {8'h00, r[31:16]}};
  endfunction : expect_of
  task automatic access(input logic [32:0] r);
    @(negedge i_clk); i_rd_page_we = 1; i_page_wdata = r[15:8];
    @(negedge i_clk); i_rd_page_we = 0; i_wr_page_we = 1; i_page_wdata = r[7:0];
    @(negedge i_clk); i_wr_page_we = 0; i_req = 1; i_write = r[32]; i_addr = r[31:16];
    @(negedge i_clk); i_req = 0;
  endtask : access
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    logic [27:0] x;
    repeat (4) @(negedge i_clk);
    chk({o_rd_page, o_wr_page, o_valid}, {eds_pkg::RD_PAGE_RESET, eds_pkg::WR_PAGE_RESET, 1'b0});
    i_arst_n = 1;
    foreach (rows[k]) begin
      access(rows[k]);
      x = expect_of(rows[k]);
      chk({o_valid, o_write, o_addr_trap, o_to_prog, o_to_ext, o_to_base}, {1'b1, rows[k][32], x[27:24]});
      chk(o_ea, x[23:0]);
      chk({o_rd_page, o_wr_page}, rows[k][15:0]);
      e = x[26:0];
      @(negedge i_clk);
      chk(seen, e);
    end
    // page load beside a read, then a back-to-back read
    i_rd_page_we = 1; i_page_wdata = 8'h07; i_req = 1; i_write = 0; i_addr = 16'h8000;
    @(negedge i_clk); i_rd_page_we = 0; i_addr = 16'h8001;
    chk(o_ea, 24'h800000);
    chk(o_rd_page, 8'h07);
    @(negedge i_clk); i_req = 0;
    chk({o_valid, o_to_ext, o_ea}, {2'b11, 24'h070001});
    // mid-run reset, then reset pages used at once
    i_arst_n = 0;
    repeat (2) @(negedge i_clk);
    chk({o_rd_page, o_wr_page, o_valid, o_write, o_addr_trap, o_to_prog, o_to_ext, o_to_base},
      {eds_pkg::RD_PAGE_RESET, eds_pkg::WR_PAGE_RESET, 6'h00});
    chk(o_ea, 24'h000000);
    i_arst_n = 1;
    i_req = 1;
    i_addr = 16'h8004;
    @(negedge i_clk);
    i_write = 1;
    i_addr = 16'h8006;
    chk({o_valid, o_to_ext, o_ea}, {2'b11, eds_pkg::RD_PAGE_RESET, 16'h0004});
    @(negedge i_clk);
    i_req = 0;
    chk({o_write, o_to_ext, o_ea}, {2'b11, eds_pkg::WR_PAGE_RESET, 16'h0006});
    report_and_stop();
  end
endmodule : tb_top
